// file: logic/card_port_pkg.sv
package card_port_pkg;
    localparam int ADDR_W = 11;
    localparam int TF_SEL_W = 3;
    localparam logic [1:0] MODE_MEMORY = 2'h0;
    localparam logic [1:0] MODE_IO = 2'h1;
    localparam logic [1:0] MODE_TASKFILE = 2'h2;
    // access kind codes
    localparam logic [2:0] KIND_NONE = 3'h0;
    localparam logic [2:0] KIND_COMMON = 3'h1;
    localparam logic [2:0] KIND_ATTRIB = 3'h2;
    localparam logic [2:0] KIND_IOPORT = 3'h3;
    localparam logic [2:0] KIND_TASKFILE = 3'h4;
    localparam logic [2:0] KIND_CONTROL = 3'h5;
    localparam logic [2:0] KIND_DMA = 3'h6;
    // byte lane codes: bit0 even lane used, bit1 odd lane used, bit2 odd steered low
    localparam logic [2:0] LANE_NONE = 3'h0;
    localparam logic [2:0] LANE_EVEN = 3'h1;
    localparam logic [2:0] LANE_ODD_HIGH = 3'h2;
    localparam logic [2:0] LANE_WORD = 3'h3;
    localparam logic [2:0] LANE_ODD_LOW = 3'h4;
    // status-change enable bit inside the card config-and-status value
    localparam int CSR_CHANGE_ENABLE_BIT = 6;
    localparam logic RESET_LEVEL_HIGH = 1'b1;
endpackage : card_port_pkg

// file: logic/card_port_if.sv
`timescale 1ns/100ps
interface card_port_if;
    import card_port_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic attribSelect_n;
    logic lowByteEnable_n;
    logic highByteEnable_n;
    logic dmaAcknowledge_n;
    logic batteryStatusOne;
    logic batteryStatusTwo;
    logic statusChange_n;
    logic audioOut_n;
    logic cardDetectOne_n;
    logic cardDetectTwo_n;
    // two-way handshake lines, open drain: oe low means pulling low
    logic passDiagDevOut;
    logic passDiagDevOe;
    logic passDiagHostOut;
    logic passDiagHostOe;
    logic activityDevOut;
    logic activityDevOe;
    logic activityHostOut;
    logic activityHostOe;
    wire passDiagnostic_n = (!passDiagDevOe && !passDiagDevOut) ||
                            (!passDiagHostOe && !passDiagHostOut) ? 1'b0 : 1'b1;
    wire activitySlavePresent_n = (!activityDevOe && !activityDevOut) ||
                                  (!activityHostOe && !activityHostOut) ? 1'b0 : 1'b1;
    modport device (
        input addr, attribSelect_n, lowByteEnable_n, highByteEnable_n, dmaAcknowledge_n,
        input passDiagnostic_n, activitySlavePresent_n,
        output batteryStatusOne, batteryStatusTwo, statusChange_n, audioOut_n,
        output cardDetectOne_n, cardDetectTwo_n,
        output passDiagDevOut, passDiagDevOe, activityDevOut, activityDevOe
    );
    modport host (
        output addr, attribSelect_n, lowByteEnable_n, highByteEnable_n, dmaAcknowledge_n,
        input passDiagnostic_n, activitySlavePresent_n,
        input batteryStatusOne, batteryStatusTwo, statusChange_n, audioOut_n,
        input cardDetectOne_n, cardDetectTwo_n,
        output passDiagHostOut, passDiagHostOe, activityHostOut, activityHostOe
    );
endinterface : card_port_if

// file: logic/card_select_decode.sv
`timescale 1ns/100ps
module card_select_decode
    import card_port_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    card_port_if.device port,
    input wire logic [1:0] mode,
    input wire logic dmaActive,
    input wire logic [7:0] configStatus,
    input wire logic cardReady,
    input wire logic writeProtect,
    input wire logic passDiagDrive,
    input wire logic activityDrive,
    output logic [2:0] accessKind,
    output logic [ADDR_W-1:0] accessAddr,
    output logic [2:0] byteLane,
    output logic passDiagSeen,
    output logic activitySeen
);
    typedef struct packed {
        logic [1:0] syncA0, syncA1;
        logic [ADDR_W-1:0] addr0, addr1;
        logic [2:0] ctl0, ctl1;
        logic [1:0] hs0, hs1;
        logic lastReady, lastProtect;
        logic [2:0] kind;
        logic [ADDR_W-1:0] outAddr;
        logic [2:0] lane;
        logic change_n, bvdOne, bvdTwo, audio_n, pdOut, daOut;
        logic pdSeen, daSeen;
    } state_t;
    // everything the block remembers sits in one register
    state_t r, next_r;
    // decoded views of the synchronised pins, active high
    logic ce1;
    logic ce2;
    logic attrib;
    logic dma_acknowledge_n;
    // status-change sources
    logic readyMoved;
    logic protectMoved;
    logic changeAllowed;

    ////////////////////////////////////////////////////////////////////////
    // the decode below is written for these widths only
    if (TF_SEL_W != 3) begin : g_bad_select_width
        $error("task-file select must be three address bits");
    end
    if (ADDR_W <= TF_SEL_W) begin : g_bad_addr_width
        $error("address must be wider than the task-file select");
    end
    if (CSR_CHANGE_ENABLE_BIT > 7) begin : g_bad_enable_bit
        $error("status-change enable bit outside the config value");
    end

    ////////////////////////////////////////////////////////////////////////
    // pins from the host are asynchronous, so two flops before any decode
    always_comb begin
        next_r = r;
        next_r.addr0 = port.addr;
        next_r.addr1 = r.addr0;
        next_r.ctl0 = {port.lowByteEnable_n, port.highByteEnable_n, port.attribSelect_n};
        next_r.ctl1 = r.ctl0;
        next_r.syncA0 = {port.dmaAcknowledge_n, 1'b0};
        next_r.syncA1 = r.syncA0;
        // handshake lines are resolved wires that the far end also pulls
        next_r.hs0 = {port.passDiagnostic_n, port.activitySlavePresent_n};
        next_r.hs1 = r.hs0;
        ce1 = !r.ctl1[2];
        ce2 = !r.ctl1[1];
        attrib = !r.ctl1[0];
        // a floating acknowledge reads as anything, so it counts only while dma runs
        dma_acknowledge_n = !r.syncA1[1] && dmaActive;
        next_r.kind = KIND_NONE;
        next_r.lane = LANE_NONE;
        next_r.outAddr = r.addr1;
        case (mode)
            MODE_TASKFILE: begin
                // chip selects share the enable pins in this mode
                next_r.outAddr = {{(ADDR_W-TF_SEL_W){1'b0}}, r.addr1[TF_SEL_W-1:0]};
                if (dma_acknowledge_n) begin
                    // dma wins over a select so a stray select cannot split a word
                    next_r.kind = KIND_DMA;
                    next_r.lane = LANE_WORD;
                end else if (ce1) begin
                    next_r.kind = KIND_TASKFILE;
                    // only the data register moves words; the rest are bytes
                    if (r.addr1[TF_SEL_W-1:0] == 3'h0) begin
                        next_r.lane = LANE_WORD;
                    end else begin
                        next_r.lane = LANE_EVEN;
                    end
                end else if (ce2) begin
                    next_r.kind = KIND_CONTROL;
                    next_r.lane = LANE_EVEN;
                end
            end
            MODE_MEMORY, MODE_IO: begin
                if (ce1 || ce2) begin
                    if (!attrib) begin
                        next_r.kind = KIND_COMMON;
                    end else if (mode == MODE_IO) begin
                        next_r.kind = KIND_IOPORT;
                    end else begin
                        next_r.kind = KIND_ATTRIB;
                    end
                end
                case ({ce1, ce2})
                    2'b11: begin
                        next_r.lane = LANE_WORD;
                    end
                    2'b01: begin
                        next_r.lane = LANE_ODD_HIGH;
                    end
                    2'b10: begin
                        // a narrow host reads the odd byte on the low lane
                        next_r.lane = r.addr1[0] ? LANE_ODD_LOW : LANE_EVEN;
                    end
                    default: begin
                        next_r.lane = LANE_NONE;
                    end
                endcase
            end
            default: begin
                // unused mode code: no access is recognised
                next_r.kind = KIND_NONE;
            end
        endcase
        ////////////////////////////////////////////////////////////////////
        // fixed levels and status change
        next_r.bvdOne = 1'b1;
        next_r.bvdTwo = 1'b1;
        next_r.audio_n = 1'b1;
        next_r.lastReady = cardReady;
        next_r.lastProtect = writeProtect;
        readyMoved = cardReady != r.lastReady;
        protectMoved = writeProtect != r.lastProtect;
        changeAllowed = (mode == MODE_IO) && configStatus[CSR_CHANGE_ENABLE_BIT];
        // one-cycle low per change; a change while disabled is dropped, not queued
        next_r.change_n = !(changeAllowed && (readyMoved || protectMoved));
        // open drain: pull only in task-file mode, watch through the synchroniser
        next_r.pdOut = !(mode == MODE_TASKFILE && passDiagDrive);
        next_r.daOut = !(mode == MODE_TASKFILE && activityDrive);
        next_r.pdSeen = (mode == MODE_TASKFILE) && !r.hs1[1];
        next_r.daSeen = (mode == MODE_TASKFILE) && !r.hs1[0];
        // reset parks the synchronisers at the idle pin levels, so no false edge follows
        if (srst) begin
            next_r = '0;
            next_r.change_n = 1'b1;
            next_r.bvdOne = 1'b1;
            next_r.bvdTwo = 1'b1;
            next_r.audio_n = 1'b1;
            next_r.pdOut = 1'b1;
            next_r.daOut = 1'b1;
            next_r.ctl0 = 3'h7;
            next_r.ctl1 = 3'h7;
            next_r.syncA0 = 2'h2;
            next_r.syncA1 = 2'h2;
            next_r.hs0 = 2'h3;
            next_r.hs1 = 2'h3;
        end
    end

    // single register stage for the whole state
    always_ff @(posedge clk) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // every pin and output except the constant card detects and handshake drive levels comes straight from the state register
    assign port.batteryStatusOne = r.bvdOne;
    assign port.batteryStatusTwo = r.bvdTwo;
    assign port.statusChange_n = r.change_n;
    assign port.audioOut_n = r.audio_n;
    // card detects are ground ties on the card, not state
    assign port.cardDetectOne_n = 1'b0;
    assign port.cardDetectTwo_n = 1'b0;
    // open drain: enable low only while pulling low
    assign port.passDiagDevOut = 1'b0;
    assign port.passDiagDevOe = r.pdOut;
    assign port.activityDevOut = 1'b0;
    assign port.activityDevOe = r.daOut;
    assign accessKind = r.kind;
    assign accessAddr = r.outAddr;
    assign byteLane = r.lane;
    assign passDiagSeen = r.pdSeen;
    assign activitySeen = r.daSeen;
endmodule : card_select_decode

// file: logic/card_host_drive.sv
`timescale 1ns/100ps
module card_host_drive
    import card_port_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    card_port_if.host port,
    input wire logic [1:0] mode,
    input wire logic reqValid,
    input wire logic reqAttrib,
    input wire logic reqDma,
    input wire logic reqControl,
    input wire logic [1:0] reqLanes,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic passDiagDrive,
    input wire logic activityDrive,
    output logic cardSeated,
    output logic statusChanged,
    output logic passDiagSeen,
    output logic activitySeen
);
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic attrib_n, lo_n, hi_n, dma_acknowledge_n_n, pd, da;
        logic [4:0] s0, s1;
        logic seated, changed, pdSeen, daSeen;
    } state_t;
    state_t r, next_r;

    always_comb begin
        next_r = r;
        next_r.s0 = {port.cardDetectOne_n, port.cardDetectTwo_n,
                     port.statusChange_n, port.passDiagnostic_n,
                     port.activitySlavePresent_n};
        next_r.s1 = r.s0;
        next_r.addr = '0;
        next_r.attrib_n = 1'b1;
        next_r.lo_n = 1'b1;
        next_r.hi_n = 1'b1;
        next_r.dma_acknowledge_n_n = 1'b1;
        if (reqValid) begin
            if (mode == MODE_TASKFILE) begin
                next_r.addr = {{(ADDR_W-TF_SEL_W){1'b0}}, reqAddr[TF_SEL_W-1:0]};
                if (reqDma) begin
                    next_r.dma_acknowledge_n_n = 1'b0;
                end else begin
                    next_r.lo_n = reqControl;
                    next_r.hi_n = !reqControl;
                end
            end else begin
                next_r.addr = reqAddr;
                next_r.attrib_n = !reqAttrib;
                next_r.lo_n = !reqLanes[0];
                next_r.hi_n = !reqLanes[1];
            end
        end
        next_r.pd = !(mode == MODE_TASKFILE && passDiagDrive);
        next_r.da = !(mode == MODE_TASKFILE && activityDrive);
        next_r.seated = !r.s1[4] && !r.s1[3];
        next_r.changed = (mode == MODE_IO) && !r.s1[2];
        next_r.pdSeen = (mode == MODE_TASKFILE) && !r.s1[1];
        next_r.daSeen = (mode == MODE_TASKFILE) && !r.s1[0];
        if (srst) begin
            next_r = '0;
            next_r.attrib_n = 1'b1;
            next_r.lo_n = 1'b1;
            next_r.hi_n = 1'b1;
            next_r.dma_acknowledge_n_n = 1'b1;
            next_r.pd = 1'b1;
            next_r.da = 1'b1;
            next_r.s0 = 5'h1F;
            next_r.s1 = 5'h1F;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign port.addr = r.addr;
    assign port.attribSelect_n = r.attrib_n;
    assign port.lowByteEnable_n = r.lo_n;
    assign port.highByteEnable_n = r.hi_n;
    assign port.dmaAcknowledge_n = r.dma_acknowledge_n_n;
    assign port.passDiagHostOut = 1'b0;
    assign port.passDiagHostOe = r.pd;
    assign port.activityHostOut = 1'b0;
    assign port.activityHostOe = r.da;
    assign cardSeated = r.seated;
    assign statusChanged = r.changed;
    assign passDiagSeen = r.pdSeen;
    assign activitySeen = r.daSeen;
endmodule : card_host_drive

// file: verif/card_port_properties.sv
`timescale 1ns/100ps
module card_port_properties
    import card_port_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] mode,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic lowByteEnable_n,
    input wire logic highByteEnable_n,
    input wire logic dmaAcknowledge_n,
    input wire logic batteryStatusOne,
    input wire logic batteryStatusTwo,
    input wire logic statusChange_n,
    input wire logic audioOut_n,
    input wire logic cardDetectOne_n,
    input wire logic cardDetectTwo_n,
    input wire logic passDiagDevOut,
    input wire logic passDiagDevOe,
    input wire logic activityDevOe
);
    // registered outputs lag a mode change, so judge only once the mode has settled
    logic [2:0] modeAge;
    logic [1:0] lastMode;
    wire settled = (modeAge >= 3'h4) && (mode == lastMode);
    always_ff @(posedge clk) begin
        lastMode <= mode;
        if (srst || mode != lastMode)
            modeAge <= 3'h0;
        else if (modeAge != 3'h7)
            modeAge <= modeAge + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_battery_one_high: assert property (
        settled && mode == MODE_MEMORY |-> batteryStatusOne)
        else $error("battery one low in memory mode");
    chk_battery_two_high: assert property (
        settled && mode == MODE_MEMORY |-> batteryStatusTwo)
        else $error("battery two low in memory mode");
    chk_audio_negated: assert property (settled && mode == MODE_IO |-> audioOut_n)
        else $error("audio asserted in io mode");
    chk_detect_grounded: assert property (!cardDetectOne_n && !cardDetectTwo_n)
        else $error("card detect not grounded");
    chk_change_pulse_short: assert property ($fell(statusChange_n) |=> statusChange_n)
        else $error("status change held longer than one cycle");
    chk_change_io_only: assert property (!statusChange_n |-> $past(mode) == MODE_IO)
        else $error("status change outside io mode");
    chk_diag_open_drain: assert property (
        !passDiagDevOut &&
        (!(settled && mode != MODE_TASKFILE) || (passDiagDevOe && activityDevOe)))
        else $error("handshake line driven wrongly");
    chk_dma_selects_off: assert property (
        !dmaAcknowledge_n |-> lowByteEnable_n && highByteEnable_n)
        else $error("chip select during dma acknowledge");
    chk_upper_addr_ground: assert property (
        settled && mode == MODE_TASKFILE |-> addr[ADDR_W-1:TF_SEL_W] == '0)
        else $error("upper address not grounded");
    cov_change: cover property ($fell(statusChange_n));
    cov_dma: cover property (!dmaAcknowledge_n);
    cov_diag: cover property (!passDiagDevOe);
endmodule : card_port_properties

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import card_port_pkg::*;
    logic clk, srst, dmaActive, cardReady, writeProtect, devPass, devAct, hostPass, hostAct;
    logic [1:0] mode;
    logic [7:0] configStatus;
    logic reqValid, reqAttrib, reqDma, reqControl;
    logic [1:0] reqLanes;
    logic [ADDR_W-1:0] reqAddr, accessAddr;
    logic [2:0] accessKind, byteLane;
    logic devPassSeen, devActSeen, cardSeated, statusChanged, hostPassSeen, hostActSeen;
    int num_errors = 0;
    int num_checks = 0;
    card_port_if port();
    card_select_decode u_card_select_decode (.clk(clk), .srst(srst), .port(port), .mode(mode),
        .dmaActive(dmaActive), .configStatus(configStatus), .cardReady(cardReady),
        .writeProtect(writeProtect), .passDiagDrive(devPass), .activityDrive(devAct),
        .accessKind(accessKind), .accessAddr(accessAddr), .byteLane(byteLane),
        .passDiagSeen(devPassSeen), .activitySeen(devActSeen));
    card_host_drive u_card_host_drive (.clk(clk), .srst(srst), .port(port), .mode(mode),
        .reqValid(reqValid), .reqAttrib(reqAttrib), .reqDma(reqDma), .reqControl(reqControl),
        .reqLanes(reqLanes), .reqAddr(reqAddr), .passDiagDrive(hostPass),
        .activityDrive(hostAct), .cardSeated(cardSeated), .statusChanged(statusChanged),
        .passDiagSeen(hostPassSeen), .activitySeen(hostActSeen));
    card_port_properties u_card_port_properties (.clk(clk), .srst(srst), .mode(mode),
        .addr(port.addr), .lowByteEnable_n(port.lowByteEnable_n),
        .highByteEnable_n(port.highByteEnable_n), .dmaAcknowledge_n(port.dmaAcknowledge_n),
        .batteryStatusOne(port.batteryStatusOne), .batteryStatusTwo(port.batteryStatusTwo),
        .statusChange_n(port.statusChange_n), .audioOut_n(port.audioOut_n),
        .cardDetectOne_n(port.cardDetectOne_n), .cardDetectTwo_n(port.cardDetectTwo_n),
        .passDiagDevOut(port.passDiagDevOut), .passDiagDevOe(port.passDiagDevOe),
        .activityDevOe(port.activityDevOe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        num_checks++;
        if (seen !== expected) begin
            num_errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, expected);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles
    // req is {attrib, dma, control}; host adds one stage, decode three more
    task automatic access(input logic [2:0] req, input logic [1:0] lanes,
        input logic [ADDR_W-1:0] a, input logic [2:0] expKind, input logic [2:0] expLane,
        input logic [ADDR_W-1:0] expAddr);
        {reqAttrib, reqDma, reqControl} = req;
        reqLanes = lanes;
        reqAddr = a;
        reqValid = 1'b1;
        cycles(4);
        check(accessKind, expKind);
        check(byteLane, expLane);
        if (expKind != KIND_NONE)
            check(accessAddr, expAddr);
        reqValid = 1'b0;
        cycles(4);
        check(accessKind, KIND_NONE);
    endtask : access
    task automatic pulse(input logic expected);
        logic seen;
        logic seenHost;
        seen = 1'b0;
        seenHost = 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (port.statusChange_n === 1'b0)
                seen = 1'b1;
            if (statusChanged === 1'b1)
                seenHost = 1'b1;
        end
        check(seen, expected);
        check(seenHost, expected);
    endtask : pulse
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {mode, dmaActive, configStatus, cardReady, writeProtect} = '0;
        {devPass, devAct, hostPass, hostAct, reqValid, reqAttrib, reqDma, reqControl} = '0;
        reqLanes = 2'h0;
        reqAddr = '0;
        srst = 1'b1;
        cycles(20);
        srst = 1'b0;
        cycles(4);
        check(cardSeated, 1'b1);
        check({port.batteryStatusOne, port.batteryStatusTwo}, 2'h3);
        access(3'h0, 2'h3, 11'h000, KIND_COMMON, LANE_WORD, 11'h000);
        access(3'h0, 2'h2, 11'h011, KIND_COMMON, LANE_ODD_HIGH, 11'h011);
        access(3'h0, 2'h1, 11'h011, KIND_COMMON, LANE_ODD_LOW, 11'h011);
        access(3'h0, 2'h1, 11'h010, KIND_COMMON, LANE_EVEN, 11'h010);
        access(3'h4, 2'h1, 11'h200, KIND_ATTRIB, LANE_EVEN, 11'h200);
        $display("memory card test done");
        mode = MODE_IO;
        cycles(6);
        check(port.audioOut_n, 1'b1);
        access(3'h4, 2'h3, 11'h1F0, KIND_IOPORT, LANE_WORD, 11'h1F0);
        configStatus = 8'h40;
        cardReady = 1'b1;
        pulse(1'b1);
        configStatus = 8'h00;
        writeProtect = 1'b1;
        pulse(1'b0);
        configStatus = 8'h40;
        writeProtect = 1'b0;
        pulse(1'b1);
        $display("io card test done");
        mode = MODE_TASKFILE;
        cycles(6);
        access(3'h0, 2'h1, 11'h7FB, KIND_TASKFILE, LANE_EVEN, 11'h003);
        access(3'h0, 2'h1, 11'h000, KIND_TASKFILE, LANE_WORD, 11'h000);
        access(3'h1, 2'h1, 11'h006, KIND_CONTROL, LANE_EVEN, 11'h006);
        access(3'h2, 2'h3, 11'h000, KIND_NONE, LANE_NONE, 11'h000);
        dmaActive = 1'b1;
        access(3'h2, 2'h3, 11'h000, KIND_DMA, LANE_WORD, 11'h000);
        devPass = 1'b1;
        cycles(4);
        check({port.passDiagnostic_n, hostPassSeen, devPassSeen}, 3'h3);
        devPass = 1'b0;
        hostAct = 1'b1;
        cycles(4);
        check({port.activitySlavePresent_n, devActSeen, hostActSeen, hostPassSeen}, 4'h6);
        hostAct = 1'b0;
        $display("task file test done");
        tally_and_finish();
    end
endmodule : testbench
